/* File: shared/wakeup_irq_params.svh */
`ifndef WAKEUP_IRQ_PARAMS_SVH
`define WAKEUP_IRQ_PARAMS_SVH
`define ADDR_WAKE_FLAGS  4'h0
`define ADDR_WAKE_EDGE   4'h1
`define ADDR_EXT_FLAGS   4'h2
`define ADDR_EXT_EDGE    4'h3
`define ADDR_PMR_FIRST   4'h4
`define ADDR_PMR_THIRD   4'h5
`define ADDR_PMR_FIFTH   4'h6
`define ADDR_WAKE_ENABLE 4'h7
`define ADDR_EXT_ENABLE  4'h8
`define ADDR_IRQ_STATUS  4'h9
`define ADDR_IRQ_MASK    4'hA
`define PMR_FIRST_EXT_LSB 1
`define PMR_THIRD_EXT_BIT 0
`define RESET_BYTE 8'h00
`define RESET_EXT  5'h00
`define STAT_WAKE_BIT 0
`define STAT_EXT_BIT  1
`endif

/* File: shared/wakeup_irq_pkg.sv */
package wakeup_irq_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;
	typedef enum logic [0:0] {
		EDGE_FALLING,
		EDGE_RISING
	} edge_sel_t;
endpackage

/* File: hw/wakeup_irq_flags.sv */
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "wakeup_irq_params.svh"
module wakeup_irq_flags (
	// Clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	// Register port
	input  wire wakeup_irq_pkg::reg_req_t  bus_req,
	output logic [7:0]                     bus_rdata,
	// Pins, active low
	input  wire logic [7:0]                wakeup_pins_n,
	input  wire logic [4:0]                ext_pins_n,
	// Interrupts
	output logic                           wakeup_irq,
	output logic                           ext_irq,
	output logic                           irq
);

	logic [7:0] wake_meta_reg;
	logic [7:0] wake_s1_reg;
	logic [7:0] wake_s2_reg;
	logic [7:0] wake_lvl_reg;
	logic [4:0] ext_meta_reg;
	logic [4:0] ext_s1_reg;
	logic [4:0] ext_s2_reg;
	logic [4:0] ext_lvl_reg;
	logic [7:0] wakeup_flag_register;
	logic [7:0] wakeup_edge_register;
	logic [4:0] ext_request_flag_register;
	logic [4:0] ext_edge_register;
	logic [7:0] port_mode_reg_first;
	logic [7:0] port_mode_reg_third;
	logic [7:0] port_mode_reg_fifth;
	logic [7:0] wake_enable_reg;
	logic [4:0] ext_enable_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic       pmr_touch_reg;
	logic [7:0] wake_lvl_next;
	logic [4:0] ext_lvl_next;
	logic [7:0] wake_set;
	logic [4:0] ext_set;
	logic [4:0] ext_func;
	logic [4:0] ext_func_next;
	logic [7:0] wake_clr;
	logic [4:0] ext_clr;
	logic       wr_ok;

	function automatic logic hit(input wakeup_irq_pkg::reg_req_t r, input logic [3:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	function automatic logic is_pmr(input logic [3:0] a);
		is_pmr = (a == `ADDR_PMR_FIRST) || (a == `ADDR_PMR_THIRD) || (a == `ADDR_PMR_FIFTH);
	endfunction

	// Three-stage synchronisers; a change counts when stages two and three agree.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_meta_reg <= 8'hFF;
			wake_s1_reg   <= 8'hFF;
			wake_s2_reg   <= 8'hFF;
			wake_lvl_reg  <= 8'hFF;
			ext_meta_reg  <= 5'h1F;
			ext_s1_reg    <= 5'h1F;
			ext_s2_reg    <= 5'h1F;
			ext_lvl_reg   <= 5'h1F;
		end else begin
			wake_meta_reg <= wakeup_pins_n;
			wake_s1_reg   <= wake_meta_reg;
			wake_s2_reg   <= wake_s1_reg;
			wake_lvl_reg  <= wake_lvl_next;
			ext_meta_reg  <= ext_pins_n;
			ext_s1_reg    <= ext_meta_reg;
			ext_s2_reg    <= ext_s1_reg;
			ext_lvl_reg   <= ext_lvl_next;
		end
	end

	// Function bits of the external inputs come from two mode registers.
	assign ext_func = {port_mode_reg_first[`PMR_FIRST_EXT_LSB+3:`PMR_FIRST_EXT_LSB],
		port_mode_reg_third[`PMR_THIRD_EXT_BIT]};
	assign ext_func_next = {bus_req.wdata[`PMR_FIRST_EXT_LSB+3:`PMR_FIRST_EXT_LSB],
		bus_req.wdata[`PMR_THIRD_EXT_BIT]};

	// A clear in the cycle right after a mode register access is dropped.
	assign wr_ok = !pmr_touch_reg;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_wake
			assign wake_lvl_next[i] = (wake_s1_reg[i] == wake_s2_reg[i]) ?
				wake_s2_reg[i] : wake_lvl_reg[i];
			assign wake_set[i] = (wake_enable_reg[i] &&
				((wake_lvl_reg[i] && !wake_lvl_next[i] && !wakeup_edge_register[i]) ||
				(!wake_lvl_reg[i] && wake_lvl_next[i] && wakeup_edge_register[i])))
				|| (hit(bus_req, `ADDR_PMR_FIFTH) && !port_mode_reg_fifth[i] &&
				bus_req.wdata[i] && !wake_lvl_reg[i]);
			assign wake_clr[i] = hit(bus_req, `ADDR_WAKE_FLAGS) && wr_ok && !bus_req.wdata[i];
		end
		for (i = 0; i < 5; i++) begin : g_ext
			assign ext_lvl_next[i] = (ext_s1_reg[i] == ext_s2_reg[i]) ?
				ext_s2_reg[i] : ext_lvl_reg[i];
			assign ext_set[i] = (ext_enable_reg[i] &&
				((ext_lvl_reg[i] && !ext_lvl_next[i] && !ext_edge_register[i]) ||
				(!ext_lvl_reg[i] && ext_lvl_next[i] && ext_edge_register[i])))
				|| ((i == 0 ? hit(bus_req, `ADDR_PMR_THIRD) : hit(bus_req, `ADDR_PMR_FIRST))
				&& !ext_lvl_reg[i] &&
				((!ext_func[i] && ext_func_next[i] && !ext_edge_register[i]) ||
				(ext_func[i] && !ext_func_next[i] && ext_edge_register[i])));
			assign ext_clr[i] = hit(bus_req, `ADDR_EXT_FLAGS) && wr_ok && !bus_req.wdata[i];
		end
	endgenerate

	// Request flags: set wins over clear, nothing but a write clears them.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wakeup_flag_register      <= `RESET_BYTE;
			ext_request_flag_register <= `RESET_EXT;
		end else begin
			wakeup_flag_register      <= (wakeup_flag_register & ~wake_clr) | wake_set;
			ext_request_flag_register <= (ext_request_flag_register & ~ext_clr) | ext_set;
		end
	end

	// Control registers.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wakeup_edge_register <= `RESET_BYTE;
			ext_edge_register    <= `RESET_EXT;
			port_mode_reg_first  <= `RESET_BYTE;
			port_mode_reg_third  <= `RESET_BYTE;
			port_mode_reg_fifth  <= `RESET_BYTE;
			wake_enable_reg      <= `RESET_BYTE;
			ext_enable_reg       <= `RESET_EXT;
			irq_mask_reg         <= 2'h0;
			pmr_touch_reg        <= 1'b0;
		end else begin
			pmr_touch_reg <= (bus_req.wr || bus_req.rd) && is_pmr(bus_req.addr);
			if (hit(bus_req, `ADDR_WAKE_EDGE))
				wakeup_edge_register <= bus_req.wdata;
			if (hit(bus_req, `ADDR_EXT_EDGE))
				ext_edge_register <= bus_req.wdata[4:0];
			if (hit(bus_req, `ADDR_PMR_FIRST))
				port_mode_reg_first <= bus_req.wdata;
			if (hit(bus_req, `ADDR_PMR_THIRD))
				port_mode_reg_third <= bus_req.wdata;
			if (hit(bus_req, `ADDR_PMR_FIFTH))
				port_mode_reg_fifth <= bus_req.wdata;
			if (hit(bus_req, `ADDR_WAKE_ENABLE))
				wake_enable_reg <= bus_req.wdata;
			if (hit(bus_req, `ADDR_EXT_ENABLE))
				ext_enable_reg <= bus_req.wdata[4:0];
			if (hit(bus_req, `ADDR_IRQ_MASK))
				irq_mask_reg <= bus_req.wdata[1:0];
		end
	end

	// Sticky summary status; a read clears it, but a new event in that cycle wins.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_reg <= 2'h0;
		end else begin
			irq_status_reg <= ((bus_req.rd && bus_req.addr == `ADDR_IRQ_STATUS) ?
				2'h0 : irq_status_reg) | {|ext_set, |wake_set};
		end
	end

	// Read data one cycle after the strobe; unmapped addresses read zero.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				`ADDR_WAKE_FLAGS:  bus_rdata <= wakeup_flag_register;
				`ADDR_WAKE_EDGE:   bus_rdata <= wakeup_edge_register;
				`ADDR_EXT_FLAGS:   bus_rdata <= {3'h0, ext_request_flag_register};
				`ADDR_EXT_EDGE:    bus_rdata <= {3'h0, ext_edge_register};
				`ADDR_PMR_FIRST:   bus_rdata <= port_mode_reg_first;
				`ADDR_PMR_THIRD:   bus_rdata <= port_mode_reg_third;
				`ADDR_PMR_FIFTH:   bus_rdata <= port_mode_reg_fifth;
				`ADDR_WAKE_ENABLE: bus_rdata <= wake_enable_reg;
				`ADDR_EXT_ENABLE:  bus_rdata <= {3'h0, ext_enable_reg};
				`ADDR_IRQ_STATUS:  bus_rdata <= {6'h00, irq_status_reg};
				`ADDR_IRQ_MASK:    bus_rdata <= {6'h00, irq_mask_reg};
				default:           bus_rdata <= 8'h00;
			endcase
		end else begin
			bus_rdata <= 8'h00;
		end
	end

	// Interrupt outputs registered; they lag the flags by one cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wakeup_irq <= 1'b0;
			ext_irq    <= 1'b0;
			irq        <= 1'b0;
		end else begin
			wakeup_irq <= |(wakeup_flag_register & wake_enable_reg);
			ext_irq    <= |(ext_request_flag_register & ext_enable_reg);
			irq        <= |(irq_status_reg & irq_mask_reg);
		end
	end

	chk_wake_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wakeup_irq == $past(|(wakeup_flag_register & wake_enable_reg)))
		else $error("wakeup irq does not follow enabled flags");
	chk_flag_set_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|wake_set) |=> ((wakeup_flag_register & $past(wake_set)) == $past(wake_set)))
		else $error("wakeup flag not set by event");
	chk_flag_no_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!hit(bus_req, `ADDR_WAKE_FLAGS) |=>
		((wakeup_flag_register & $past(wakeup_flag_register)) == $past(wakeup_flag_register)))
		else $error("wakeup flag dropped without a write");
	chk_write_one_noop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(hit(bus_req, `ADDR_WAKE_FLAGS) && bus_req.wdata == 8'hFF && wake_set == 8'h00) |=>
		wakeup_flag_register == $past(wakeup_flag_register))
		else $error("writing ones changed wakeup flags");
	chk_clear_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(pmr_touch_reg && hit(bus_req, `ADDR_WAKE_FLAGS)) |=>
		((wakeup_flag_register & $past(wakeup_flag_register)) == $past(wakeup_flag_register)))
		else $error("clear right after mode access took effect");
	chk_clear_works: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!pmr_touch_reg && hit(bus_req, `ADDR_WAKE_FLAGS) && bus_req.wdata == 8'h00 &&
		wake_set == 8'h00) |=> wakeup_flag_register == 8'h00)
		else $error("wakeup clear failed");
	chk_edge_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hit(bus_req, `ADDR_WAKE_EDGE) |=> wakeup_edge_register == $past(bus_req.wdata))
		else $error("edge register write lost");
	chk_pmr_wake_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(hit(bus_req, `ADDR_PMR_FIFTH) && !port_mode_reg_fifth[0] && bus_req.wdata[0] &&
		!wake_lvl_reg[0]) |=> wakeup_flag_register[0])
		else $error("function switch while low did not set flag");
	chk_ext_rise_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(hit(bus_req, `ADDR_PMR_THIRD) && !ext_func[0] && bus_req.wdata[0] &&
		!ext_lvl_reg[0] && !ext_edge_register[0]) |=> ext_request_flag_register[0])
		else $error("ext flag not set on function enable");
	chk_ext_fall_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(hit(bus_req, `ADDR_PMR_FIRST) && ext_func[1] && !bus_req.wdata[1] &&
		!ext_lvl_reg[1] && ext_edge_register[1]) |=> ext_request_flag_register[1])
		else $error("ext flag not set on function disable");

	// The external flags follow the same keep-until-cleared rules as the wakeup flags.

	chk_ext_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ext_irq == $past(|(ext_request_flag_register & ext_enable_reg)))
		else $error("ext irq does not follow enabled flags");

	chk_sum_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		irq == $past(|(irq_status_reg & irq_mask_reg)))
		else $error("summary irq does not follow masked status");

	chk_ext_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!hit(bus_req, `ADDR_EXT_FLAGS) |=> ((ext_request_flag_register &
		$past(ext_request_flag_register)) == $past(ext_request_flag_register)))
		else $error("ext flag dropped without a write");

	chk_ext_set_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|ext_set) |=> ((ext_request_flag_register & $past(ext_set)) == $past(ext_set)))
		else $error("ext flag not set by event");

	chk_ext_clr_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(pmr_touch_reg && hit(bus_req, `ADDR_EXT_FLAGS)) |=> ((ext_request_flag_register &
		$past(ext_request_flag_register)) == $past(ext_request_flag_register)))
		else $error("ext clear right after mode access took effect");

	chk_ext_clear_works: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!pmr_touch_reg && hit(bus_req, `ADDR_EXT_FLAGS) && bus_req.wdata == 8'h00 &&
		ext_set == 5'h00) |=> ext_request_flag_register == 5'h00)
		else $error("ext clear failed");

	chk_ext_one_noop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(hit(bus_req, `ADDR_EXT_FLAGS) && bus_req.wdata == 8'hFF && ext_set == 5'h00) |=>
		ext_request_flag_register == $past(ext_request_flag_register))
		else $error("writing ones changed ext flags");

	chk_edge_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!hit(bus_req, `ADDR_WAKE_EDGE) |=> $stable(wakeup_edge_register))
		else $error("edge register changed without a write");

	chk_first_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hit(bus_req, `ADDR_PMR_FIRST) |=> port_mode_reg_first == $past(bus_req.wdata))
		else $error("first mode register write lost");

	chk_third_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hit(bus_req, `ADDR_PMR_THIRD) |=> port_mode_reg_third == $past(bus_req.wdata))
		else $error("third mode register write lost");

	chk_fifth_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hit(bus_req, `ADDR_PMR_FIFTH) |=> port_mode_reg_fifth == $past(bus_req.wdata))
		else $error("fifth mode register write lost");

	chk_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hit(bus_req, `ADDR_WAKE_ENABLE) |=> wake_enable_reg == $past(bus_req.wdata))
		else $error("wake enable write lost");

	chk_ext_edge_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hit(bus_req, `ADDR_EXT_EDGE) |=> ext_edge_register == $past(bus_req.wdata[4:0]))
		else $error("ext edge register write lost");

	chk_mask_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hit(bus_req, `ADDR_IRQ_MASK) |=> irq_mask_reg == $past(bus_req.wdata[1:0]))
		else $error("mask register write lost");

	chk_wake_fall_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wake_enable_reg[0] && wake_lvl_reg[0] && !wake_lvl_next[0] &&
		!wakeup_edge_register[0]) |=> wakeup_flag_register[0])
		else $error("falling edge did not set flag");

	chk_wake_rise_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wake_enable_reg[7] && !wake_lvl_reg[7] && wake_lvl_next[7] &&
		wakeup_edge_register[7]) |=> wakeup_flag_register[7])
		else $error("rising edge did not set flag");

	chk_wake_no_spur: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wake_set == 8'h00) |=>
		((wakeup_flag_register & ~$past(wakeup_flag_register)) == 8'h00))
		else $error("wakeup flag rose without an event");

	chk_fifth_set_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(hit(bus_req, `ADDR_PMR_FIFTH) && !port_mode_reg_fifth[7] && bus_req.wdata[7] &&
		!wake_lvl_reg[7]) |=> wakeup_flag_register[7])
		else $error("function switch on top pin did not set flag");

	chk_ext_first_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(hit(bus_req, `ADDR_PMR_FIRST) && !ext_func[4] && bus_req.wdata[4] &&
		!ext_lvl_reg[4] && !ext_edge_register[4]) |=> ext_request_flag_register[4])
		else $error("ext flag 4 not set on function enable");

	chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!bus_req.rd |=> bus_rdata == 8'h00)
		else $error("read data shown without a read");

	chk_rdata_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(bus_req.rd && bus_req.addr == `ADDR_WAKE_FLAGS) |=>
		bus_rdata == $past(wakeup_flag_register))
		else $error("flag read returned wrong data");

	chk_status_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|wake_set) |=> irq_status_reg[`STAT_WAKE_BIT])
		else $error("wake status not set");

	chk_status_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|ext_set) |=> irq_status_reg[`STAT_EXT_BIT])
		else $error("ext status not set");

	chk_touch_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
		((bus_req.wr || bus_req.rd) && is_pmr(bus_req.addr)) |=> pmr_touch_reg)
		else $error("mode access did not open the block window");

	// A level only moves once two synchroniser stages agree, which filters single-cycle glitches.

	chk_lvl_agree: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wake_s1_reg[0] != wake_s2_reg[0]) |=> $stable(wake_lvl_reg[0]))
		else $error("pin level moved before stages agreed");

endmodule // wakeup_irq_flags

/* File: verification/pin_model.sv */
`timescale 1ns/1ps
module pin_model (
	// Pins toward the block, active low
	output logic [7:0] wakeup_pins_n,
	output logic [4:0] ext_pins_n
);
	// Pins idle high so that release from reset sees no edge.
	initial begin
		wakeup_pins_n = 8'hFF;
		ext_pins_n    = 5'h1F;
	end
	task automatic drive(input logic [7:0] w, input logic [4:0] e);
		wakeup_pins_n <= w;
		ext_pins_n    <= e;
	endtask
endmodule // pin_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`include "wakeup_irq_params.svh"
module testbench;
	logic                     clk_sys;
	logic                     rst_n;
	wakeup_irq_pkg::reg_req_t bus_req;
	logic [7:0]               bus_rdata;
	logic [7:0]               wakeup_pins_n;
	logic [4:0]               ext_pins_n;
	logic                     wakeup_irq;
	logic                     ext_irq;
	logic                     irq;
	int                       n_fail;
	int                       checked;
	int                       cycles;
	logic [7:0]               rd_val;

	pin_model u_pins (.wakeup_pins_n(wakeup_pins_n), .ext_pins_n(ext_pins_n));
	wakeup_irq_flags u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.wakeup_pins_n(wakeup_pins_n), .ext_pins_n(ext_pins_n),
		.wakeup_irq(wakeup_irq), .ext_irq(ext_irq), .irq(irq)
	);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// A hang counts as a mismatch and ends the run.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail = n_fail + 1;
			test_done();
		end
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req <= '0;
	endtask

	// Two writes on consecutive edges, no idle cycle between them.
	task automatic wr2(input logic [3:0] a0, input logic [7:0] d0, input logic [3:0] a1,
			input logic [7:0] d1);
		@(posedge clk_sys);
		bus_req <= '{addr: a0, wdata: d0, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req <= '{addr: a1, wdata: d1, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req <= '0;
		#1 rd_val = bus_rdata;
	endtask

	task automatic t_reset_and_rw();
		rd(`ADDR_WAKE_EDGE);
		check("edge reset", rd_val, 8'h00);
		rd(`ADDR_WAKE_FLAGS);
		check("flags reset", rd_val, 8'h00);
		wr(`ADDR_WAKE_EDGE, 8'hA5);
		rd(`ADDR_WAKE_EDGE);
		check("edge rw", rd_val, 8'hA5);
	endtask

	task automatic t_pin_edges();
		wr(`ADDR_WAKE_ENABLE, 8'hFF);
		wr(`ADDR_WAKE_EDGE, 8'h00);
		u_pins.drive(8'hF7, 5'h1F);
		waitc(8);
		rd(`ADDR_WAKE_FLAGS);
		check("falling pin3", rd_val, 8'h08);
		check("wake irq", {7'h00, wakeup_irq}, 8'h01);
		wr(`ADDR_WAKE_FLAGS, 8'hFF);
		rd(`ADDR_WAKE_FLAGS);
		check("write ones", rd_val, 8'h08);
		wr(`ADDR_WAKE_EDGE, 8'h08);
		wr(`ADDR_WAKE_FLAGS, 8'hF7);
		rd(`ADDR_WAKE_FLAGS);
		check("clear zero", rd_val, 8'h00);
		check("wake irq off", {7'h00, wakeup_irq}, 8'h00);
		u_pins.drive(8'hFF, 5'h1F);
		waitc(8);
		rd(`ADDR_WAKE_FLAGS);
		check("rising pin3", rd_val, 8'h08);
		wr(`ADDR_WAKE_FLAGS, 8'h00);
	endtask

	task automatic t_func_switch();
		// The mask stays at zero across every mode write.
		wr(`ADDR_WAKE_ENABLE, 8'h00);
		u_pins.drive(8'hDF, 5'h0E);
		waitc(8);
		rd(`ADDR_WAKE_FLAGS);
		check("disabled pin", rd_val, 8'h00);
		wr2(`ADDR_PMR_FIFTH, 8'h20, `ADDR_WAKE_FLAGS, 8'h00);
		rd(`ADDR_WAKE_FLAGS);
		check("switch set, clear blocked", rd_val, 8'h20);
		wr(`ADDR_WAKE_FLAGS, 8'h00);
		rd(`ADDR_WAKE_FLAGS);
		check("later clear", rd_val, 8'h00);
		wr(`ADDR_EXT_EDGE, 8'h01);
		wr(`ADDR_PMR_THIRD, 8'h01);
		rd(`ADDR_EXT_FLAGS);
		check("ext0 wrong way", rd_val, 8'h00);
		wr(`ADDR_PMR_FIRST, 8'h10);
		wr(`ADDR_PMR_THIRD, 8'h00);
		rd(`ADDR_EXT_FLAGS);
		check("ext switch", rd_val, 8'h11);
	endtask

	task automatic t_irq();
		wr(`ADDR_IRQ_MASK, 8'h02);
		waitc(3);
		check("irq raised", {7'h00, irq}, 8'h01);
		wr(`ADDR_IRQ_MASK, 8'h00);
		waitc(3);
		check("irq masked", {7'h00, irq}, 8'h00);
		wr(`ADDR_EXT_ENABLE, 8'h11);
		waitc(2);
		check("ext irq", {7'h00, ext_irq}, 8'h01);
		wr(`ADDR_EXT_FLAGS, 8'h00);
		rd(`ADDR_EXT_FLAGS);
		check("ext cleared", rd_val, 8'h00);
		check("ext irq off", {7'h00, ext_irq}, 8'h00);
		rd(`ADDR_IRQ_STATUS);
		check("status", rd_val, 8'h03);
		wr(`ADDR_IRQ_MASK, 8'h03);
		waitc(3);
		check("irq cleared", {7'h00, irq}, 8'h00);
	endtask

	initial begin
		n_fail  = 0;
		checked = 0;
		cycles  = 0;
		bus_req = '0;
		rst_n   = 1'b0;
		waitc(3);
		rst_n <= 1'b1;
		waitc(3);
		t_reset_and_rw();
		t_pin_edges();
		t_func_switch();
		t_irq();
		test_done();
	end
endmodule // testbench
